//--- core/tcc_defines.vh
`ifndef TCC_DEFINES_VH
`define TCC_DEFINES_VH

// ==========================================
// Register byte offsets
`define TCC_OFS_CTRL1 8'h00
`define TCC_OFS_MODE 8'h04
`define TCC_OFS_CTRL2 8'h08
`define TCC_OFS_STAT 8'h0c
`define TCC_OFS_CNT 8'h10
`define TCC_OFS_GRA 8'h14
`define TCC_OFS_GRB 8'h18
`define TCC_OFS_GRC 8'h1c
`define TCC_OFS_GRD 8'h20

// ==========================================
// Field positions
`define TCC_C1_SRC_LSB 0
`define TCC_C1_SRC_MSB 2
`define TCC_C1_CLRA_BIT 7
`define TCC_MD_RUN_BIT 0
`define TCC_MD_PWM_MODE_TWO_BIT 1
`define TCC_C2_STOP_BIT 0
`define TCC_C2_FILT_BIT 1
`define TCC_C2_CAPEN_LSB 4
`define TCC_C2_CAPEN_MSB 7
`define TCC_ST_CAP_LSB 0
`define TCC_ST_CAP_MSB 3
`define TCC_ST_CMPA_BIT 4

// ==========================================
// Reset values and codes
`define TCC_RST_CTRL1 8'h00
`define TCC_RST_MODE 2'h0
`define TCC_RST_CTRL2 8'h00
`define TCC_RST_STAT 5'h00
`define TCC_RST_CNT 16'h0000
`define TCC_RST_GR 16'hffff
`define TCC_SRC_OSC40 3'h6
`define TCC_SRC_FAST 3'h7
`define TCC_SRC_BUS 3'h0
`define TCC_RESP_OKAY 2'h0
`define TCC_RESP_SLVERR 2'h2
`define TCC_FILT_ONES 3'h7
`define TCC_FILT_ZEROS 3'h0

`endif

//--- core/tcc_capture.v
`timescale 1ns/10ps
`include "tcc_defines.vh"

module tcc_capture (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Pin and filter control
  input wire pin,
  input wire filt_en,
  input wire filt_tick,
  // Capture request
  output wire edge_pulse
);

  reg smp_ff;
  reg [2:0] hist_ff;
  reg lvl_ff;
  reg prev_ff;
  wire cur_lvl;

  // ==========================================
  // Sampling and optional filter
  // Pin is synchronous to aclk, so one sampling stage suffices
  always @(posedge aclk) begin
    if (!aresetn) begin
      smp_ff <= 1'b0;
      hist_ff <= `TCC_FILT_ZEROS;
      lvl_ff <= 1'b0;
      prev_ff <= 1'b0;
    end else begin
      smp_ff <= pin;
      if (filt_tick) begin
        hist_ff <= {hist_ff[1:0], smp_ff};
        // Level changes only after three equal samples
        if (hist_ff == `TCC_FILT_ONES) begin
          lvl_ff <= 1'b1;
        end else if (hist_ff == `TCC_FILT_ZEROS) begin
          lvl_ff <= 1'b0;
        end
      end
      prev_ff <= cur_lvl;
    end
  end

  assign cur_lvl = filt_en ? lvl_ff : smp_ff;
  assign edge_pulse = cur_lvl & ~prev_ff;

endmodule

//--- core/tcc_timer.v
`timescale 1ns/10ps
`include "tcc_defines.vh"

// Function
// - Compare match A clears counter when enabled
// - Clear beats simultaneous software counter write
// - Code 111 selects fast oscillator source
// - Capture copies counter one or two cycles after a pin edge with the filter off
// - Four capture channels with own registers
// - PWM_MODE_TWO stop-on-compare halts count at match
// - Code 110 selects 40MHz oscillator source
// - Run bit starts and stops counter

module tcc_timer #(
  parameter FILT_DIV = 4,
  parameter CNT_W = 16
) (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // AXI4-Lite write address
  input wire [7:0] s_axi_awaddr,
  input wire s_axi_awvalid,
  output wire s_axi_awready,
  // AXI4-Lite write data
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output wire s_axi_wready,
  // AXI4-Lite write response
  output wire [1:0] s_axi_bresp,
  output wire s_axi_bvalid,
  input wire s_axi_bready,
  // AXI4-Lite read address
  input wire [7:0] s_axi_araddr,
  input wire s_axi_arvalid,
  output wire s_axi_arready,
  // AXI4-Lite read data
  output wire [31:0] s_axi_rdata,
  output wire [1:0] s_axi_rresp,
  output wire s_axi_rvalid,
  input wire s_axi_rready,
  // Count sources, levels sampled on aclk
  input wire [4:0] aux_src,
  input wire osc_40mhz_clock,
  input wire fast_osc_clock,
  // Capture pins A to D
  input wire [3:0] capture_pin
);

  // ==========================================
  // Byte-lane merge
  function [31:0] merge;
    input [31:0] old_v;
    input [31:0] new_v;
    input [3:0] strb;
    integer i;
    begin
      merge = old_v;
      for (i = 0; i < 4; i = i + 1) begin
        if (strb[i]) begin
          merge[i*8 +: 8] = new_v[i*8 +: 8];
        end
      end
    end
  endfunction

  // ==========================================
  // Bus slave state
  reg awready_ff, wready_ff, bvalid_ff, arready_ff, rvalid_ff;
  reg [1:0] bresp_ff, rresp_ff;
  reg [31:0] rdata_ff;
  reg aw_held_ff, w_held_ff;
  reg [7:0] awaddr_ff;
  reg [31:0] wdata_ff;
  reg [3:0] wstrb_ff;

  // Registers
  reg [7:0] ctrl1_ff;
  reg [1:0] mode_ff;
  reg [7:0] ctrl2_ff;
  reg [4:0] stat_ff;
  reg [CNT_W-1:0] cnt_ff;
  reg [CNT_W-1:0] gr_ff [0:3];
  reg [7:0] src_prev_ff;
  reg [7:0] fdiv_ff;

  reg [CNT_W-1:0] nxt_cnt;
  reg [1:0] nxt_mode;
  reg [4:0] nxt_stat;
  reg [31:0] rd_val;
  reg rd_ok;
  reg [31:0] wr_old;
  reg wr_ok;

  wire wr_go = aw_held_ff & w_held_ff & ~bvalid_ff;
  wire [31:0] wr_val;
  wire [7:0] src_vec = {fast_osc_clock, osc_40mhz_clock, aux_src, 1'b1};
  wire [2:0] src_sel = ctrl1_ff[`TCC_C1_SRC_MSB:`TCC_C1_SRC_LSB];
  wire tick;
  wire match_a = (cnt_ff == gr_ff[0]);
  wire running = mode_ff[`TCC_MD_RUN_BIT];
  wire clr_a = ctrl1_ff[`TCC_C1_CLRA_BIT];
  wire pwm_mode_two_stop = mode_ff[`TCC_MD_PWM_MODE_TWO_BIT] & ctrl2_ff[`TCC_C2_STOP_BIT];
  wire step = running & tick;
  wire do_clear = step & match_a & clr_a;
  wire do_stop = step & match_a & pwm_mode_two_stop;
  wire filt_tick = (fdiv_ff == 8'h00);
  wire [3:0] cap_edge;
  wire [3:0] cap_en = ctrl2_ff[`TCC_C2_CAPEN_MSB:`TCC_C2_CAPEN_LSB];
  wire [3:0] cap_hit = cap_edge & cap_en;
  wire [7:0] fdiv_last = FILT_DIV[7:0] - 8'h01;

  // ==========================================
  // Count source edge selection
  // Code 0 counts every aclk; 110 and 111 pick the oscillators
  assign tick = (src_sel == `TCC_SRC_BUS) ? 1'b1 :
                (src_vec[src_sel] & ~src_prev_ff[src_sel]);

  always @(posedge aclk) begin
    if (!aresetn) begin
      src_prev_ff <= 8'h00;
      fdiv_ff <= 8'h00;
    end else begin
      src_prev_ff <= src_vec;
      fdiv_ff <= filt_tick ? fdiv_last : fdiv_ff - 8'h01;
    end
  end

  // ==========================================
  // Capture channels
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_cap
      tcc_capture u_cap (
        .aclk(aclk),
        .aresetn(aresetn),
        .pin(capture_pin[g]),
        .filt_en(ctrl2_ff[`TCC_C2_FILT_BIT]),
        .filt_tick(filt_tick),
        .edge_pulse(cap_edge[g])
      );
    end
  endgenerate

  // ==========================================
  // Read mux
  always @* begin
    rd_ok = 1'b1;
    rd_val = 32'h00000000;
    case (s_axi_araddr)
      `TCC_OFS_CTRL1: rd_val = {24'h000000, ctrl1_ff};
      `TCC_OFS_MODE: rd_val = {30'h00000000, mode_ff};
      `TCC_OFS_CTRL2: rd_val = {24'h000000, ctrl2_ff};
      `TCC_OFS_STAT: rd_val = {27'h0000000, stat_ff};
      `TCC_OFS_CNT: rd_val = {16'h0000, cnt_ff};
      `TCC_OFS_GRA: rd_val = {16'h0000, gr_ff[0]};
      `TCC_OFS_GRB: rd_val = {16'h0000, gr_ff[1]};
      `TCC_OFS_GRC: rd_val = {16'h0000, gr_ff[2]};
      `TCC_OFS_GRD: rd_val = {16'h0000, gr_ff[3]};
      default: rd_ok = 1'b0;
    endcase
  end

  // Old contents of the write target (all ones for STAT), for byte-lane merge
  always @* begin
    wr_ok = 1'b1;
    wr_old = 32'h00000000;
    case (awaddr_ff)
      `TCC_OFS_CTRL1: wr_old = {24'h000000, ctrl1_ff};
      `TCC_OFS_MODE: wr_old = {30'h00000000, mode_ff};
      `TCC_OFS_CTRL2: wr_old = {24'h000000, ctrl2_ff};
      `TCC_OFS_STAT: wr_old = 32'hffffffff;
      `TCC_OFS_CNT: wr_old = {16'h0000, cnt_ff};
      `TCC_OFS_GRA: wr_old = {16'h0000, gr_ff[0]};
      `TCC_OFS_GRB: wr_old = {16'h0000, gr_ff[1]};
      `TCC_OFS_GRC: wr_old = {16'h0000, gr_ff[2]};
      `TCC_OFS_GRD: wr_old = {16'h0000, gr_ff[3]};
      default: wr_ok = 1'b0;
    endcase
  end

  assign wr_val = merge(wr_old, wdata_ff, wstrb_ff);

  // ==========================================
  // Counter, mode and status next values
  always @* begin
    nxt_cnt = cnt_ff;
    if (step) begin
      if (match_a & pwm_mode_two_stop) begin
        nxt_cnt = cnt_ff;
      end else begin
        nxt_cnt = cnt_ff + 1'b1;
      end
    end
    if (wr_go && awaddr_ff == `TCC_OFS_CNT) begin
      nxt_cnt = wr_val[CNT_W-1:0];
    end
    // Clear overrides a write landing in the same cycle
    if (do_clear) begin
      nxt_cnt = `TCC_RST_CNT;
    end
  end

  always @* begin
    nxt_mode = mode_ff;
    if (wr_go && awaddr_ff == `TCC_OFS_MODE) begin
      nxt_mode = wr_val[1:0];
    end
    // Hardware stop wins over a colliding mode write
    if (do_stop) begin
      nxt_mode[`TCC_MD_RUN_BIT] = 1'b0;
    end
  end

  // Status bits clear on writing 0; a new event in the same cycle wins
  always @* begin
    nxt_stat = stat_ff;
    if (wr_go && awaddr_ff == `TCC_OFS_STAT) begin
      nxt_stat = stat_ff & wr_val[4:0];
    end
    nxt_stat[`TCC_ST_CAP_MSB:`TCC_ST_CAP_LSB] = nxt_stat[`TCC_ST_CAP_MSB:`TCC_ST_CAP_LSB] | cap_hit;
    nxt_stat[`TCC_ST_CMPA_BIT] = nxt_stat[`TCC_ST_CMPA_BIT] | (step & match_a);
  end

  // ==========================================
  // Register file
  integer k;
  always @(posedge aclk) begin
    if (!aresetn) begin
      ctrl1_ff <= `TCC_RST_CTRL1;
      mode_ff <= `TCC_RST_MODE;
      ctrl2_ff <= `TCC_RST_CTRL2;
      stat_ff <= `TCC_RST_STAT;
      cnt_ff <= `TCC_RST_CNT;
      for (k = 0; k < 4; k = k + 1) begin
        gr_ff[k] <= `TCC_RST_GR;
      end
    end else begin
      cnt_ff <= nxt_cnt;
      mode_ff <= nxt_mode;
      stat_ff <= nxt_stat;
      if (wr_go && awaddr_ff == `TCC_OFS_CTRL1) begin
        ctrl1_ff <= wr_val[7:0];
      end
      if (wr_go && awaddr_ff == `TCC_OFS_CTRL2) begin
        ctrl2_ff <= wr_val[7:0];
      end
      for (k = 0; k < 4; k = k + 1) begin
        // Capture takes the counter one cycle after the sampled edge
        if (cap_hit[k]) begin
          gr_ff[k] <= cnt_ff;
        end else if (wr_go && awaddr_ff == (`TCC_OFS_GRA + k[7:0] * 8'h04)) begin
          gr_ff[k] <= wr_val[CNT_W-1:0];
        end
      end
    end
  end

  // ==========================================
  // AXI4-Lite handshakes, one write and one read in flight
  always @(posedge aclk) begin
    if (!aresetn) begin
      awready_ff <= 1'b1;
      wready_ff <= 1'b1;
      bvalid_ff <= 1'b0;
      bresp_ff <= `TCC_RESP_OKAY;
      aw_held_ff <= 1'b0;
      w_held_ff <= 1'b0;
      awaddr_ff <= 8'h00;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      arready_ff <= 1'b1;
      rvalid_ff <= 1'b0;
      rresp_ff <= `TCC_RESP_OKAY;
      rdata_ff <= 32'h00000000;
    end else begin
      if (s_axi_awvalid && awready_ff) begin
        awready_ff <= 1'b0;
        aw_held_ff <= 1'b1;
        awaddr_ff <= s_axi_awaddr;
      end
      if (s_axi_wvalid && wready_ff) begin
        wready_ff <= 1'b0;
        w_held_ff <= 1'b1;
        wdata_ff <= s_axi_wdata;
        wstrb_ff <= s_axi_wstrb;
      end
      if (wr_go) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        bvalid_ff <= 1'b1;
        bresp_ff <= wr_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
      if (bvalid_ff && s_axi_bready) begin
        bvalid_ff <= 1'b0;
        awready_ff <= 1'b1;
        wready_ff <= 1'b1;
      end
      if (s_axi_arvalid && arready_ff) begin
        arready_ff <= 1'b0;
        rvalid_ff <= 1'b1;
        rdata_ff <= rd_val;
        rresp_ff <= rd_ok ? `TCC_RESP_OKAY : `TCC_RESP_SLVERR;
      end
      if (rvalid_ff && s_axi_rready) begin
        rvalid_ff <= 1'b0;
        arready_ff <= 1'b1;
      end
    end
  end

  assign s_axi_awready = awready_ff;
  assign s_axi_wready = wready_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_arready = arready_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rresp = rresp_ff;
  assign s_axi_rdata = rdata_ff;

endmodule

//--- dv/tcc_timer_chk.sv
`timescale 1ns/10ps
// ========
// Bus handshake checker
module tcc_timer_chk (
  // Clock and reset
  input wire aclk,
  input wire aresetn,
  // Write side
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wvalid,
  input wire s_axi_wready,
  input wire [1:0] s_axi_bresp,
  input wire s_axi_bvalid,
  input wire s_axi_bready,
  // Read side
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [31:0] s_axi_rdata,
  input wire s_axi_rvalid,
  input wire s_axi_rready
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  sequence s_wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence s_rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
    else $error("write response dropped early");
  a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped early");
  a_b_latency: assert property (s_wr_taken |-> ##2 s_axi_bvalid)
    else $error("write response late");
  a_r_latency: assert property (s_rd_taken |=> s_axi_rvalid)
    else $error("read data late");
  a_wr_blocked: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while answering");
  a_rd_blocked: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while answering");
  a_b_release: assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
    else $error("write response not retired");
  a_r_release: assert property (s_axi_rvalid && s_axi_rready |=> !s_axi_rvalid && s_axi_arready)
    else $error("read response not retired");
endmodule
bind tcc_timer tcc_timer_chk u_chk (.aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
  .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

//--- dv/tcc_cap_src.sv
`timescale 1ns/10ps
// ========
// Capture pin source, idle low
module tcc_cap_src (
  // Clock
  input wire aclk,
  // Pins A to D
  output logic [3:0] capture_pin
);
  initial capture_pin = 4'h0;
  // Never shorter than the filtered minimum width of three equal samples
  task pulse(input int ch, input int w);
    capture_pin[ch] <= 1'b1;
    repeat ((w < 3) ? 3 : w) @(posedge aclk);
    capture_pin[ch] <= 1'b0;
  endtask
endmodule

//--- dv/test_tcc_timer.sv
`timescale 1ns/10ps
`include "tcc_defines.vh"
module test_tcc_timer;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, o40, ofs;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rv, c0, g;
  logic [3:0] wstrb;
  logic [4:0] aux;
  logic [1:0] bresp, rresp, br, rr;
  wire awready, wready, bvalid, arready, rvalid;
  wire [3:0] pins;
  int n_mismatch, compares, seed, k, f, n;
  int codes[7] = '{1, 2, 3, 4, 5, 6, 7};
  tcc_timer #(.FILT_DIV(1), .CNT_W(16)) dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .aux_src(aux), .osc_40mhz_clock(o40), .fast_osc_clock(ofs), .capture_pin(pins));
  tcc_cap_src cap (.aclk(aclk), .capture_pin(pins));
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // ========
  // Checks and verdict
  task report_and_stop;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  function automatic logic [31:0] rst_val(input logic [7:0] a);
    return (a >= `TCC_OFS_GRA) ? 32'h0000ffff : 32'h00000000;
  endfunction
  // ========
  // Bus master, one edge of idle first so strobes never change twice at once
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
      if (bvalid === 1'b1) break;
    end
    br = bresp; bready <= 1'b0;
    if (i == 99) begin n_mismatch++; report_and_stop; end
  endtask
  task automatic rd(input logic [7:0] a);
    int i;
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    for (i = 0; i < 99; i++) begin
      @(posedge aclk);
      if (arready) arvalid <= 1'b0;
      if (rvalid === 1'b1) break;
    end
    rv = rdata; rr = rresp; rready <= 1'b0;
    if (i == 99) begin n_mismatch++; report_and_stop; end
  endtask
  // Slow square edges on the chosen count source, ending low
  task edges(input int c, input int cnt);
    repeat (2 * cnt) begin
      if (c == 6) o40 <= ~o40; else if (c == 7) ofs <= ~ofs; else aux[c-1] <= ~aux[c-1];
      repeat (2) @(posedge aclk);
    end
  endtask
  // ========
  // Main sequence
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, o40, ofs} = 7'h00;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; wstrb = 4'hf; aux = 5'h00;
    aresetn = 1'b0; n_mismatch = 0; compares = 0; seed = 32'h45445f4a;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    for (k = 0; k < 9; k++) begin rd(k * 4); chk(rv, rst_val(k * 4)); end
    rd(8'h24); chk({rr, rv[29:0]}, 32'h80000000);
    wr(8'h24, 32'h1); chk(br, `TCC_RESP_SLVERR);
    foreach (codes[j]) begin
      wr(`TCC_OFS_MODE, 32'h0);
      // Sources already idle, so no oscillator stops right after a switch
      wr(`TCC_OFS_CTRL1, codes[j]);
      wr(`TCC_OFS_CNT, 32'h0);
      wr(`TCC_OFS_MODE, 32'h1);
      n = 1 + ($random(seed) & 7);
      edges(codes[j], n);
      wr(`TCC_OFS_MODE, 32'h0);
      rd(`TCC_OFS_CNT); chk(rv, n);
    end
    g = 8 + ($random(seed) & 31);
    wr(`TCC_OFS_CTRL1, 32'h0); wr(`TCC_OFS_GRA, g); wr(`TCC_OFS_CNT, 32'h0);
    wr(`TCC_OFS_CTRL2, 32'h1); wr(`TCC_OFS_MODE, 32'h3);
    // Only reads while waiting, so no mode write meets the match
    for (k = 0; k < 30; k++) begin rd(`TCC_OFS_MODE); if (rv[0] === 1'b0) break; end
    chk(rv, 32'h2);
    rd(`TCC_OFS_CNT); chk(rv, g);
    rd(`TCC_OFS_STAT); chk(rv[4], 1'b1);
    wr(`TCC_OFS_CTRL2, 32'h0); wr(`TCC_OFS_CTRL1, 32'h80); wr(`TCC_OFS_GRA, 32'h3);
    wr(`TCC_OFS_CNT, 32'h0); wr(`TCC_OFS_MODE, 32'h1); wr(`TCC_OFS_MODE, 32'h0);
    rd(`TCC_OFS_CNT); chk(rv <= 32'h3, 1'b1);
    // Counter write lands on the clear step; a won write would leave it far above match
    wr(`TCC_OFS_CNT, 32'h0); wr(`TCC_OFS_MODE, 32'h1); wr(`TCC_OFS_CNT, 32'h55); wr(`TCC_OFS_MODE, 32'h0);
    rd(`TCC_OFS_CNT); chk(rv <= 32'h3, 1'b1);
    wr(`TCC_OFS_STAT, 32'h0); rd(`TCC_OFS_STAT); chk(rv, 32'h0);
    wr(`TCC_OFS_CTRL1, 32'h0); wr(`TCC_OFS_GRA, 32'hffff);
    // Low byte lane only; upper bits keep the reset value
    wstrb <= 4'h1;
    wr(`TCC_OFS_GRB, 32'h12345678); rd(`TCC_OFS_GRB); chk(rv, 32'hff78);
    wstrb <= 4'hf;
    for (f = 0; f < 2; f++) begin
      wr(`TCC_OFS_CTRL2, 32'hf0 | (f << 1)); wr(`TCC_OFS_MODE, 32'h1);
      for (k = 0; k < 4; k++) begin
        rd(`TCC_OFS_CNT); c0 = rv;
        cap.pulse(k, f ? 8 : 3);
        rd(`TCC_OFS_GRA + 4 * k); g = rv;
        rd(`TCC_OFS_CNT); chk(g > c0 && g < rv, 1'b1);
      end
      rd(`TCC_OFS_STAT); chk(rv[3:0], 4'hf);
      wr(`TCC_OFS_STAT, 32'h0); wr(`TCC_OFS_MODE, 32'h0);
    end
    report_and_stop;
  end
endmodule
